/* src/bos_pattern_detect.sv */
module bos_pattern_detect (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // data link bits
  input wire logic link_bit,
  input wire logic link_bit_valid,
  // decoded events, one-cycle pulses
  output bos_pkg::link_event_t ev
);

  logic [15:0] shift;
  logic [3:0] ones_run;

  wire [15:0] next_shift = {shift[14:0], link_bit};
  wire [3:0] next_run = link_bit ? ones_run + 4'h1 : 4'h0;

  // zero, six bits, zero, eight ones
  wire framed = ~next_shift[15] & ~next_shift[8] &
                (next_shift[7:0] == bos_pkg::BOS_FLAG);
  wire abort_hit = (next_run == bos_pkg::ABORT_ONES);
  wire idle_hit = (next_shift[7:0] == bos_pkg::IDLE_FLAG);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift <= 16'h0000;
      ones_run <= 4'h0;
      ev <= '0;
    end else if (link_bit_valid) begin
      shift <= next_shift;
      // saturate only while ones keep coming, a zero rearms the detector
      ones_run <= (link_bit && ones_run == bos_pkg::ABORT_ONES) ?
                  ones_run : next_run;
      ev.abort <= abort_hit & (ones_run != bos_pkg::ABORT_ONES);
      ev.idle <= idle_hit;
      ev.word_valid <= framed;
      ev.word <= next_shift[14:9];
    end else begin
      ev.abort <= 1'b0;
      ev.idle <= 1'b0;
      ev.word_valid <= 1'b0;
    end
  end

endmodule

/* src/bos_pkg.sv */
package bos_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_BLOCK_IRQ_EN = 6'h00;
  localparam logic [5:0] IDX_STATUS = 6'h06;
  localparam logic [5:0] IDX_EVT_IRQ_EN = 6'h07;
  localparam logic [5:0] IDX_IRQ_CTRL = 6'h08;
  localparam logic [5:0] IDX_BUF0 = 6'h0A;
  localparam logic [5:0] IDX_BUF1 = 6'h0B;
  localparam logic [5:0] IDX_REPEAT = 6'h15;

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int BIT_BLOCK_EN = 3;
  localparam int BIT_SOT = 5;
  localparam int BIT_EOT = 3;
  localparam int BIT_ABORT = 1;
  localparam int BIT_IDLE = 0;
  localparam int BIT_CLR_ON_RD = 0;
  localparam int BIT_RX_PTR = 7;
  localparam logic [7:0] MSK_ABORT = 8'h01 << BIT_ABORT;
  localparam logic [7:0] MSK_IDLE = 8'h01 << BIT_IDLE;
  localparam logic [7:0] STATUS_MASK = 8'h2B;

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_BLOCK_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_EVT_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_IRQ_CTRL = 8'h01;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_BUF = 8'h00;
  localparam logic RST_LAST_BUF = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // line patterns
  localparam logic [7:0] IDLE_FLAG = 8'h7E;
  localparam logic [7:0] BOS_FLAG = 8'hFF;
  localparam logic [3:0] ABORT_ONES = 4'h9;

  ////////////////////////////////////////////////////////////////////////
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic abort;
    logic idle;
    logic word_valid;
    logic [5:0] word;
  } link_event_t;

endpackage

/* src/bos_receive_processor.sv */
module bos_receive_processor #(
  parameter int CNT_W = 7
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // data link bits
  input wire logic link_bit,
  input wire logic link_bit_valid,
  // write address
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // interrupt
  output logic irq
);

  generate
    if (CNT_W < 1 || CNT_W > 7) begin : g_bad_width
      $error("CNT_W must lie between 1 and 7");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [7:0] block_irq_enable;
  logic [7:0] link_event_status;
  logic [7:0] link_event_irq_enable;
  logic [7:0] irq_control_reg;
  logic [CNT_W-1:0] repeat_limit;
  logic last_buf;
  logic [7:0] rx_buf [2];

  logic active;
  logic done;
  logic [5:0] last_word;
  logic [CNT_W-1:0] rep_cnt;
  bos_pkg::link_event_t ev;

  ////////////////////////////////////////////////////////////////////////
  // line pattern detector

  bos_pattern_detect u_detect (
    .aclk(aclk),
    .aresetn(aresetn),
    .link_bit(link_bit),
    .link_bit_valid(link_bit_valid),
    .ev(ev)
  );

  ////////////////////////////////////////////////////////////////////////
  // write channels

  logic aw_got;
  logic w_got;
  logic [7:0] wa_q;
  logic [7:0] wd_q;
  logic ws_q;

  wire aw_hs = awvalid & awready;
  wire w_hs = wvalid & wready;
  wire do_write = aw_got & w_got & ~bvalid;
  wire next_aw_got = (aw_got | aw_hs) & ~do_write;
  wire next_w_got = (w_got | w_hs) & ~do_write;
  wire [5:0] w_idx = wa_q[7:2];
  wire wr_en = do_write & ws_q;

  wire wr_block = wr_en & (w_idx == bos_pkg::IDX_BLOCK_IRQ_EN);
  wire wr_status = wr_en & (w_idx == bos_pkg::IDX_STATUS);
  wire wr_evt_en = wr_en & (w_idx == bos_pkg::IDX_EVT_IRQ_EN);
  wire wr_ictl = wr_en & (w_idx == bos_pkg::IDX_IRQ_CTRL);
  wire wr_repeat = wr_en & (w_idx == bos_pkg::IDX_REPEAT);

  wire w_mapped = (w_idx == bos_pkg::IDX_BLOCK_IRQ_EN) |
                  (w_idx == bos_pkg::IDX_STATUS) |
                  (w_idx == bos_pkg::IDX_EVT_IRQ_EN) |
                  (w_idx == bos_pkg::IDX_IRQ_CTRL) |
                  (w_idx == bos_pkg::IDX_BUF0) |
                  (w_idx == bos_pkg::IDX_BUF1) |
                  (w_idx == bos_pkg::IDX_REPEAT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      wa_q <= 8'h00;
      wd_q <= 8'h00;
      ws_q <= 1'b0;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      awready <= ~next_aw_got;
      wready <= ~next_w_got;
      if (aw_hs) begin
        wa_q <= awaddr;
      end
      if (w_hs) begin
        wd_q <= wdata[7:0];
        ws_q <= wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= bos_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= w_mapped ? bos_pkg::RESP_OKAY : bos_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read channels

  wire ar_hs = arvalid & arready;
  wire next_rvalid = ar_hs | (rvalid & ~rready);
  wire [5:0] r_idx = araddr[7:2];
  wire clr_on_rd = irq_control_reg[bos_pkg::BIT_CLR_ON_RD];
  wire rd_status = ar_hs & (r_idx == bos_pkg::IDX_STATUS);
  wire [7:0] repeat_rd = {last_buf, 7'(repeat_limit)};

  wire hit_block = (r_idx == bos_pkg::IDX_BLOCK_IRQ_EN);
  wire hit_status = (r_idx == bos_pkg::IDX_STATUS);
  wire hit_evt = (r_idx == bos_pkg::IDX_EVT_IRQ_EN);
  wire hit_ictl = (r_idx == bos_pkg::IDX_IRQ_CTRL);
  wire hit_buf0 = (r_idx == bos_pkg::IDX_BUF0);
  wire hit_buf1 = (r_idx == bos_pkg::IDX_BUF1);
  wire hit_rep = (r_idx == bos_pkg::IDX_REPEAT);
  wire r_mapped = hit_block | hit_status | hit_evt | hit_ictl |
                  hit_buf0 | hit_buf1 | hit_rep;

  wire [7:0] rd_byte = hit_block ? block_irq_enable :
                       hit_status ? link_event_status :
                       hit_evt ? link_event_irq_enable :
                       hit_ictl ? irq_control_reg :
                       hit_buf0 ? rx_buf[0] :
                       hit_buf1 ? rx_buf[1] :
                       hit_rep ? repeat_rd : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= bos_pkg::RESP_OKAY;
    end else begin
      arready <= ~next_rvalid;
      rvalid <= next_rvalid;
      if (ar_hs) begin
        rdata <= {24'h000000, rd_byte};
        rresp <= r_mapped ? bos_pkg::RESP_OKAY : bos_pkg::RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_irq_enable <= bos_pkg::RST_BLOCK_IRQ_EN;
      link_event_irq_enable <= bos_pkg::RST_EVT_IRQ_EN;
      irq_control_reg <= bos_pkg::RST_IRQ_CTRL;
      repeat_limit <= '0;
    end else begin
      if (wr_block) begin
        block_irq_enable <= wd_q;
      end
      if (wr_evt_en) begin
        link_event_irq_enable <= wd_q;
      end
      if (wr_ictl) begin
        irq_control_reg <= wd_q;
      end
      if (wr_repeat) begin
        repeat_limit <= wd_q[CNT_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // message tracking

  wire new_msg = ev.word_valid & (~active | (ev.word != last_word));
  wire same_msg = ev.word_valid & ~new_msg & ~done;
  wire [CNT_W-1:0] next_cnt = new_msg ? CNT_W'(1) : rep_cnt + 1'b1;
  wire limit_on = (repeat_limit != '0);
  wire eot_ev = (new_msg | same_msg) & limit_on &
                (next_cnt == repeat_limit);
  wire stop_ev = ev.abort | ev.idle;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active <= 1'b0;
      done <= 1'b0;
      last_word <= 6'h00;
      rep_cnt <= '0;
    end else if (stop_ev) begin
      active <= 1'b0;
      done <= 1'b0;
    end else if (new_msg) begin
      active <= 1'b1;
      last_word <= ev.word;
      rep_cnt <= next_cnt;
      done <= eot_ev;
    end else if (same_msg) begin
      rep_cnt <= next_cnt;
      done <= eot_ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive buffers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_buf <= bos_pkg::RST_LAST_BUF;
    end else if (new_msg) begin
      last_buf <= ~last_buf;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_buf
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        rx_buf[i] <= bos_pkg::RST_BUF;
      end else if (new_msg && (last_buf != 1'(i))) begin
        rx_buf[i] <= {1'b0, ev.word, 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status and interrupt

  logic [7:0] status_set;
  logic [7:0] status_clr;

  always_comb begin
    status_set = 8'h00;
    status_set[bos_pkg::BIT_SOT] = new_msg;
    status_set[bos_pkg::BIT_EOT] = eot_ev;
    status_set[bos_pkg::BIT_ABORT] = ev.abort;
    status_set[bos_pkg::BIT_IDLE] = ev.idle;
  end

  // read clears or write-one clears, by the control bit
  assign status_clr = (rd_status & clr_on_rd) ? bos_pkg::STATUS_MASK :
                      (wr_status & ~clr_on_rd) ?
                      (wd_q & bos_pkg::STATUS_MASK) : 8'h00;

  // a new event wins over a clear in the same cycle
  wire [7:0] next_status = (link_event_status & ~status_clr) |
                           status_set;

  wire block_on = block_irq_enable[bos_pkg::BIT_BLOCK_EN];
  wire [7:0] armed = link_event_status & link_event_irq_enable &
                     bos_pkg::STATUS_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_event_status <= bos_pkg::RST_STATUS;
      irq <= 1'b0;
    end else begin
      link_event_status <= next_status;
      irq <= block_on & (|armed);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_block_gate;
    !block_on |=> !irq;
  endproperty
  a_block_gate: assert property (p_block_gate)
    else $error("interrupt raised with block enable off");

  property p_sot;
    new_msg |=> link_event_status[bos_pkg::BIT_SOT];
  endproperty
  a_sot: assert property (p_sot)
    else $error("start of transfer not flagged");

  property p_hold;
    !rd_status && !wr_status |=>
      ($past(link_event_status) & ~link_event_status) == 8'h00;
  endproperty
  a_hold: assert property (p_hold)
    else $error("status bit dropped without access");

  property p_clr_read;
    rd_status && clr_on_rd && status_set == 8'h00 |=>
      link_event_status == 8'h00;
  endproperty
  a_clr_read: assert property (p_clr_read)
    else $error("status not cleared by read");

  property p_abort;
    ev.abort |=> link_event_status[bos_pkg::BIT_ABORT];
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort not flagged");

  property p_idle;
    ev.idle |=> link_event_status[bos_pkg::BIT_IDLE];
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle flag not flagged");

  property p_abort_en;
    link_event_status == bos_pkg::MSK_ABORT && block_on |=>
      irq == $past(link_event_irq_enable[bos_pkg::BIT_ABORT]);
  endproperty
  a_abort_en: assert property (p_abort_en)
    else $error("abort interrupt does not follow its enable");

  property p_idle_en;
    link_event_status == bos_pkg::MSK_IDLE && block_on |=>
      irq == $past(link_event_irq_enable[bos_pkg::BIT_IDLE]);
  endproperty
  a_idle_en: assert property (p_idle_en)
    else $error("idle interrupt does not follow its enable");

  property p_buf;
    new_msg |=> last_buf != $past(last_buf) &&
      rx_buf[last_buf] == {1'b0, $past(ev.word), 1'b0};
  endproperty
  a_buf: assert property (p_buf)
    else $error("codeword octet not stored in opposite buffer");

  property p_ptr;
    ar_hs && hit_rep |=> rdata[bos_pkg::BIT_RX_PTR] == $past(last_buf);
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("buffer pointer reads wrong");

  property p_no_eot;
    !limit_on |=> !$rose(link_event_status[bos_pkg::BIT_EOT]);
  endproperty
  a_no_eot: assert property (p_no_eot)
    else $error("end of transfer with zero count");

  property p_count;
    same_msg && !stop_ev |=> rep_cnt == CNT_W'($past(rep_cnt) + 1'b1);
  endproperty
  a_count: assert property (p_count)
    else $error("repetition not counted");

  c_eot: cover property (new_msg ##[1:300] eot_ev);
  c_abort_irq: cover property (ev.abort ##2 irq);
  c_clear: cover property (rd_status && clr_on_rd && irq);

endmodule

/* tb/bos_far_end.sv */
module bos_far_end (
  // clock
  input wire logic aclk,
  // line side
  output logic link_bit,
  output logic link_bit_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    link_bit = 1'b0;
    link_bit_valid = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one strobed bit per two cycles, line inverted while unstrobed
  task automatic send_bits(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge aclk);
      link_bit <= v[i];
      link_bit_valid <= 1'b1;
      @(posedge aclk);
      link_bit <= ~v[i];
      link_bit_valid <= 1'b0;
    end
  endtask

  // zero, six bits, zero, eight ones, repeated
  task automatic send_bos(input logic [5:0] code, input int reps);
    repeat (reps) send_bits({1'b0, code, 1'b0, 8'hFF}, 16);
  endtask

  task automatic send_abort();
    send_bits(16'h01FF, 10);
  endtask

  task automatic send_idle();
    send_bits(16'h007E, 8);
  endtask
endmodule

/* tb/bos_receive_processor_test.sv */
module bos_receive_processor_test;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [7:0] addr, rst, wr, rd;
    logic [1:0] resp;
  } row_t;

  localparam logic [7:0] A_BL = {bos_pkg::IDX_BLOCK_IRQ_EN, 2'b00};
  localparam logic [7:0] A_ST = {bos_pkg::IDX_STATUS, 2'b00};
  localparam logic [7:0] A_EV = {bos_pkg::IDX_EVT_IRQ_EN, 2'b00};
  localparam logic [7:0] A_CT = {bos_pkg::IDX_IRQ_CTRL, 2'b00};
  localparam logic [7:0] A_B0 = {bos_pkg::IDX_BUF0, 2'b00};
  localparam logic [7:0] A_B1 = {bos_pkg::IDX_BUF1, 2'b00};
  localparam logic [7:0] A_RP = {bos_pkg::IDX_REPEAT, 2'b00};
  localparam logic [1:0] OK = bos_pkg::RESP_OKAY;
  localparam logic [1:0] SE = bos_pkg::RESP_SLVERR;

  logic aclk, aresetn, link_bit, link_bit_valid, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int bad_count, compares;
  row_t rows [8];

  bos_receive_processor #(.CNT_W(7)) bos_receive_processor_i (
    .aclk(aclk), .aresetn(aresetn),
    .link_bit(link_bit), .link_bit_valid(link_bit_valid),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq(irq)
  );

  bos_far_end bos_far_end_i (
    .aclk(aclk), .link_bit(link_bit), .link_bit_valid(link_bit_valid)
  );

  initial aclk = 1'b0;
  always #25 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hung(input int n);
    if (n >= 40) begin
      bad_count++;
      $display("MISMATCH %0t bus answer missing", $time);
      close_out();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                        input logic [3:0] s);
    int n;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    hung(n);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    axi_wr(a, d, 4'hF);
    chk({6'h0, r}, {6'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    hung(n);
    chk(rdata[7:0], exp);
    chk({6'h0, rresp}, {6'h0, er});
    rready <= 1'b0;
  endtask

  task automatic settle(input logic exp_irq);
    repeat (4) @(posedge aclk);
    chk({7'h0, irq}, {7'h0, exp_irq});
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, bad_count, compares} = '0;
    rows = '{'{A_BL, 8'h00, 8'hFF, 8'hFF, OK},
             '{A_ST, 8'h00, 8'hFF, 8'h00, OK},
             '{A_EV, 8'h00, 8'h5A, 8'h5A, OK},
             '{A_CT, 8'h01, 8'h01, 8'h01, OK},
             '{A_B0, 8'h00, 8'hFF, 8'h00, OK},
             '{A_B1, 8'h00, 8'hFF, 8'h00, OK},
             '{A_RP, 8'h80, 8'h7F, 8'hFF, OK},
             '{8'h04, 8'h00, 8'hFF, 8'h00, SE}};
    do_reset();
    for (int i = 0; i < 8; i++) begin
      rd(rows[i].addr, rows[i].rst, rows[i].resp);
      wr(rows[i].addr, rows[i].wr, rows[i].resp);
      rd(rows[i].addr, rows[i].rd, rows[i].resp);
    end
    // byte lane zero off: write ignored
    axi_wr(A_EV, 8'hFF, 4'hE);
    rd(A_EV, 8'h5A, OK);
    // three repetitions to end of transfer
    wr(A_BL, 8'h08, OK);
    wr(A_EV, 8'h28, OK);
    wr(A_RP, 8'h03, OK);
    bos_far_end_i.send_bos(6'b101011, 1);
    settle(1'b1);
    rd(A_ST, 8'h20, OK);
    bos_far_end_i.send_bos(6'b101011, 2);
    bos_far_end_i.send_bits(16'h0000, 8);
    settle(1'b1);
    rd(A_RP, 8'h03, OK);
    rd(A_ST, 8'h08, OK);
    rd(A_B0, 8'h56, OK);
    rd(A_ST, 8'h00, OK);
    settle(1'b0);
    // limit one, new codeword to the other buffer
    wr(A_RP, 8'h01, OK);
    bos_far_end_i.send_bos(6'b000111, 1);
    settle(1'b1);
    rd(A_ST, 8'h28, OK);
    rd(A_RP, 8'h81, OK);
    rd(A_B1, 8'h0E, OK);
    rd(A_B0, 8'h56, OK);
    // limit zero never ends
    wr(A_RP, 8'h00, OK);
    bos_far_end_i.send_bos(6'b110011, 4);
    settle(1'b1);
    rd(A_ST, 8'h20, OK);
    rd(A_RP, 8'h00, OK);
    rd(A_B0, 8'h66, OK);
    // abort and idle through the enables
    wr(A_BL, 8'h00, OK);
    wr(A_EV, 8'h02, OK);
    bos_far_end_i.send_abort();
    settle(1'b0);
    wr(A_BL, 8'h08, OK);
    settle(1'b1);
    wr(A_EV, 8'h01, OK);
    settle(1'b0);
    bos_far_end_i.send_idle();
    settle(1'b1);
    wr(A_EV, 8'h00, OK);
    settle(1'b0);
    // write-one-to-clear mode
    wr(A_CT, 8'h00, OK);
    rd(A_ST, 8'h03, OK);
    rd(A_ST, 8'h03, OK);
    wr(A_ST, 8'h02, OK);
    rd(A_ST, 8'h01, OK);
    // a second abort once a zero has broken the run
    wr(A_EV, 8'h02, OK);
    bos_far_end_i.send_abort();
    settle(1'b1);
    rd(A_ST, 8'h03, OK);
    wr(A_ST, 8'h02, OK);
    // reset in mid-run
    wr(A_EV, 8'h01, OK);
    settle(1'b1);
    do_reset();
    settle(1'b0);
    rd(A_ST, 8'h00, OK);
    rd(A_RP, 8'h80, OK);
    close_out();
  end
endmodule
